/* rtl/flash_host_ctrl.sv */
// host-side controller for a byte-wide parallel flash: read, byte
// program, sector erase, chip erase, end-of-write polling
// assumes a user port on clk and the flash wired straight to the pins
//
// Notes on behaviour
// - write cycle is WE low under CE low
// - read data only with CE and OE low
// - program is three unlock bytes plus data
// - sector erase is six cycles, last 20H
// - chip erase six cycles, 10H to 555H
// - apparent finish confirmed by two more reads
module flash_host_ctrl (
    input  wire logic                              clk,        // 25 MHz
    input  wire logic                              reset_n,    // async
    input  wire logic                              cmdValid,   // request
    input  wire logic [1:0]                        cmdOp,      // op_type
    input  wire logic [flash_host_pkg::ADDR_W-1:0] cmdAddr,    // address
    input  wire logic [flash_host_pkg::DATA_W-1:0] cmdData,    // prog byte
    output logic                                   cmdReady,   // idle
    output logic                                   rspValid,   // pulse
    output logic [flash_host_pkg::DATA_W-1:0]      rspData,    // last read
    output logic                                   rspError,   // with rsp
    output logic                                   flashCeN,   // chip sel
    output logic                                   flashOeN,   // out gate
    output logic                                   flashWeN,   // wr strobe
    output logic [flash_host_pkg::ADDR_W-1:0]      flashAddr,  // addr pins
    output logic [flash_host_pkg::DATA_W-1:0]      flashDqOut, // dq drive
    output logic                                   flashDqOe,  // dq enable
    input  wire logic [flash_host_pkg::DATA_W-1:0] flashDqIn   // dq pins
);

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_SEND    = 3'b001,
        ST_POLL    = 3'b010,
        ST_CONFIRM = 3'b011,
        ST_READ    = 3'b100
    } state_type;

    state_type                               state_r;
    flash_host_pkg::op_type                  op_r;
    logic [flash_host_pkg::ADDR_W-1:0]       addr_r;
    logic [flash_host_pkg::DATA_W-1:0]       data_r;
    logic [2:0]                              step_r;
    logic                                    confirm_r;
    logic                                    prevToggle_r;
    logic [flash_host_pkg::TIMER_W-1:0]      timer_r;
    logic                                    cycStart_r;
    logic                                    cycWrite_r;
    logic [flash_host_pkg::ADDR_W-1:0]       cycAddr_r;
    logic [flash_host_pkg::DATA_W-1:0]       cycData_r;
    logic                                    cycDone;
    logic [flash_host_pkg::DATA_W-1:0]       cycRdata;
    logic [flash_host_pkg::ADDR_W-1:0]       seqAddr;
    logic [flash_host_pkg::DATA_W-1:0]       seqData;
    logic [2:0]                              lastStep;
    logic                                    expectPoll;
    logic                                    statusDone;
    logic                                    timedOut;

    // ------------------------------------------------------------------
    // command sequence table
    // ------------------------------------------------------------------
    // each unlock cycle and command code is fixed, so the device never sees an invalid
    // cycle mid-sequence and never aborts to read mode
    // indexed by the cycle after the one on the pins: its values are
    // loaded while the current cycle runs, ready at the next start
    always_comb begin
        seqAddr = flash_host_pkg::UNLOCK1_ADDR;
        seqData = flash_host_pkg::UNLOCK1_DATA;
        case (step_r + 3'h1)
            3'h1, 3'h4: begin
                seqAddr = flash_host_pkg::UNLOCK2_ADDR;
                seqData = flash_host_pkg::UNLOCK2_DATA;
            end
            3'h2: begin
                seqData = (op_r == flash_host_pkg::OP_PROG) ?
                    flash_host_pkg::PROG_SETUP :
                    flash_host_pkg::ERASE_SETUP;
            end
            3'h3: begin
                if (op_r == flash_host_pkg::OP_PROG) begin
                    seqAddr = addr_r;
                    seqData = data_r;
                end
            end
            3'h5: begin
                if (op_r == flash_host_pkg::OP_SECTOR) begin
                    // low lines zero; only upper lines pick sector
                    seqAddr = {addr_r[flash_host_pkg::ADDR_W-1:
                                      flash_host_pkg::SECTOR_LSB],
                               7'h00};
                    seqData = flash_host_pkg::SECTOR_ERASE;
                end else begin
                    seqAddr = flash_host_pkg::CHIP_ERASE_AD;
                    seqData = flash_host_pkg::CHIP_ERASE;
                end
            end
            default: begin
                seqAddr = flash_host_pkg::UNLOCK1_ADDR;
                seqData = flash_host_pkg::UNLOCK1_DATA;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // status decode
    // ------------------------------------------------------------------
    // polled bit settles to true data after program, one after erase;
    // toggle bit must also have stopped since the previous read
    assign lastStep   = (op_r == flash_host_pkg::OP_PROG) ?
                        flash_host_pkg::PROG_LAST :
                        flash_host_pkg::ERASE_LAST;
    assign expectPoll = (op_r == flash_host_pkg::OP_PROG) ?
                        data_r[flash_host_pkg::POLL_BIT] : 1'b1;
    assign statusDone =
        (cycRdata[flash_host_pkg::POLL_BIT] == expectPoll) &&
        (cycRdata[flash_host_pkg::TOGGLE_BIT] == prevToggle_r);
    // a program still running past its longest time is a failure
    assign timedOut   = (op_r == flash_host_pkg::OP_PROG) &&
        (timer_r >= 10'(flash_host_pkg::PROG_MAX_CYC));

    // ------------------------------------------------------------------
    // operation sequencer
    // ------------------------------------------------------------------
    // cmdReady stays low from acceptance until the internal operation is
    // seen finished or a program times out, so only after a timeout can a command reach a busy device
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r      <= ST_IDLE;
            op_r         <= flash_host_pkg::OP_READ;
            addr_r       <= '0;
            data_r       <= 8'h00;
            step_r       <= 3'h0;
            confirm_r    <= 1'b0;
            prevToggle_r <= 1'b0;
            cmdReady     <= 1'b1;
            rspValid     <= 1'b0;
            rspData      <= 8'h00;
            rspError     <= 1'b0;
            cycStart_r   <= 1'b0;
            cycWrite_r   <= 1'b0;
            cycAddr_r    <= '0;
            cycData_r    <= 8'h00;
        end else begin
            cycStart_r <= 1'b0;
            rspValid   <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (cmdValid) begin
                        op_r      <= flash_host_pkg::op_type'(cmdOp);
                        addr_r    <= cmdAddr;
                        data_r    <= cmdData;
                        step_r    <= 3'h0;
                        cmdReady  <= 1'b0;
                        cycStart_r <= 1'b1;
                        if (cmdOp == flash_host_pkg::OP_READ) begin
                            cycWrite_r <= 1'b0;
                            cycAddr_r  <= cmdAddr;
                            state_r    <= ST_READ;
                        end else begin
                            cycWrite_r <= 1'b1;
                            cycAddr_r  <= flash_host_pkg::UNLOCK1_ADDR;
                            cycData_r  <= flash_host_pkg::UNLOCK1_DATA;
                            state_r    <= ST_SEND;
                        end
                    end
                end
                ST_SEND: begin
                    if (cycDone) begin
                        cycStart_r <= 1'b1;
                        if (step_r == lastStep) begin
                            // operation running; poll the target
                            cycWrite_r   <= 1'b0;
                            cycAddr_r    <= addr_r;
                            prevToggle_r <= ~data_r[flash_host_pkg::TOGGLE_BIT];
                            state_r      <= ST_POLL;
                        end else begin
                            step_r <= step_r + 3'h1;
                        end
                    end else if (!cycStart_r) begin
                        cycAddr_r <= seqAddr;
                        cycData_r <= seqData;
                    end
                end
                ST_POLL, ST_CONFIRM: begin
                    // only status reads while busy
                    if (cycDone) begin
                        prevToggle_r <= cycRdata[flash_host_pkg::TOGGLE_BIT];
                        if (statusDone && state_r == ST_CONFIRM &&
                            confirm_r) begin
                            rspValid <= 1'b1;
                            rspData  <= cycRdata;
                            rspError <= (op_r == flash_host_pkg::OP_PROG) &&
                                        (cycRdata != data_r);
                            cmdReady <= 1'b1;
                            state_r  <= ST_IDLE;
                        end else if (timedOut) begin
                            rspValid <= 1'b1;
                            rspData  <= cycRdata;
                            rspError <= 1'b1;
                            cmdReady <= 1'b1;
                            state_r  <= ST_IDLE;
                        end else begin
                            // two further valid reads must follow
                            cycStart_r <= 1'b1;
                            confirm_r  <= statusDone && state_r == ST_CONFIRM;
                            state_r    <= statusDone ? ST_CONFIRM : ST_POLL;
                        end
                    end
                end
                default: begin
                    if (cycDone) begin
                        rspValid <= 1'b1;
                        rspData  <= cycRdata;
                        rspError <= 1'b0;
                        cmdReady <= 1'b1;
                        state_r  <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // busy-time counter from operation start
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_r <= '0;
        end else if (state_r == ST_POLL || state_r == ST_CONFIRM) begin
            if (timer_r != '1) begin
                timer_r <= timer_r + 10'h001;
            end
        end else begin
            timer_r <= '0;
        end
    end

    // ------------------------------------------------------------------
    // pin cycle engine
    // ------------------------------------------------------------------
    flash_bus_cycle cycle (
        .clk     (clk),
        .reset_n (reset_n),
        .start   (cycStart_r),
        .isWrite (cycWrite_r),
        .addr    (cycAddr_r),
        .wdata   (cycData_r),
        .done    (cycDone),
        .rdata   (cycRdata),
        .ceN     (flashCeN),
        .oeN     (flashOeN),
        .weN     (flashWeN),
        .addrOut (flashAddr),
        .dqOut   (flashDqOut),
        .dqOe    (flashDqOe),
        .dqIn    (flashDqIn)
    );

endmodule

/* rtl/flash_host_pkg.sv */
// shared constants of the parallel flash host controller
// assumes a 25 MHz clk and a byte-wide flash on its own pins
package flash_host_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------------
    // timing, in ns / us as printed, then cycles of clk
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 40;
    localparam int WE_LOW_NS      = 100;
    localparam int READ_ACCESS_NS = 70;
    localparam int PROG_MAX_US    = 20;
    localparam int SYNC_STAGES    = 2;
    localparam int WE_LOW_CYC     =
        (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // access time rounded up, plus the input synchroniser delay
    localparam int READ_WAIT_CYC  =
        (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
    // longest time, rounded down
    localparam int PROG_MAX_CYC   = (PROG_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int TIMER_W        = 10;
    localparam int WAIT_W         = 4;

    // ------------------------------------------------------------------
    // command codes and unlock cycles (unlock values are plain defaults)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] UNLOCK1_ADDR  = 19'h00555;
    localparam logic [DATA_W-1:0] UNLOCK1_DATA  = 8'haa;
    localparam logic [ADDR_W-1:0] UNLOCK2_ADDR  = 19'h002aa;
    localparam logic [DATA_W-1:0] UNLOCK2_DATA  = 8'h55;
    localparam logic [DATA_W-1:0] PROG_SETUP    = 8'ha0;
    localparam logic [DATA_W-1:0] ERASE_SETUP   = 8'h80;
    localparam logic [DATA_W-1:0] SECTOR_ERASE  = 8'h20;
    localparam logic [DATA_W-1:0] CHIP_ERASE    = 8'h10;
    localparam logic [ADDR_W-1:0] CHIP_ERASE_AD = 19'h00555;
    localparam int                SECTOR_LSB    = 7;
    localparam logic [2:0]        PROG_LAST     = 3'h3;
    localparam logic [2:0]        ERASE_LAST    = 3'h5;
    localparam int                POLL_BIT      = 7;
    localparam int                TOGGLE_BIT    = 6;

    // ------------------------------------------------------------------
    // user operations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_READ   = 2'b00,
        OP_PROG   = 2'b01,
        OP_SECTOR = 2'b10,
        OP_CHIP   = 2'b11
    } op_type;

endpackage

/* rtl/flash_bus_cycle.sv */
// one strobe cycle on the flash pins, read or write
// assumes start only while idle; dqIn arrives from the pin unsynchronised
module flash_bus_cycle (
    input  wire logic                              clk,      // 25 MHz
    input  wire logic                              reset_n,  // async, low
    input  wire logic                              start,    // begin cycle
    input  wire logic                              isWrite,  // 1 write
    input  wire logic [flash_host_pkg::ADDR_W-1:0] addr,     // address
    input  wire logic [flash_host_pkg::DATA_W-1:0] wdata,    // write byte
    output logic                                   done,     // end pulse
    output logic [flash_host_pkg::DATA_W-1:0]      rdata,    // read byte
    output logic                                   ceN,      // chip select
    output logic                                   oeN,      // output gate
    output logic                                   weN,      // write strobe
    output logic [flash_host_pkg::ADDR_W-1:0]      addrOut,  // address pins
    output logic [flash_host_pkg::DATA_W-1:0]      dqOut,    // data out
    output logic                                   dqOe,     // data drive
    input  wire logic [flash_host_pkg::DATA_W-1:0] dqIn      // data pins
);

    typedef enum logic [2:0] {
        PH_IDLE    = 3'b000,
        PH_SETUP   = 3'b001,
        PH_STROBE  = 3'b010,
        PH_HOLD    = 3'b011,
        PH_RECOVER = 3'b100
    } phase_type;

    phase_type                            phase_r;
    logic [flash_host_pkg::WAIT_W-1:0]    wait_r;
    logic                                 write_r;
    logic [flash_host_pkg::DATA_W-1:0]    dqMeta_r;
    logic [flash_host_pkg::DATA_W-1:0]    dqSync_r;

    // ------------------------------------------------------------------
    // pin input synchroniser
    // ------------------------------------------------------------------
    // first stage is read only by the second
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dqMeta_r <= 8'h00;
            dqSync_r <= 8'h00;
        end else begin
            dqMeta_r <= dqIn;
            dqSync_r <= dqMeta_r;
        end
    end

    // ------------------------------------------------------------------
    // strobe sequencing
    // ------------------------------------------------------------------
    // write: address and CE first so the device takes the address at WE
    // fall; WE rises before CE so data is taken on the WE edge.
    // dq is driven only while OE is high, so the pins never fight.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_r <= PH_IDLE;
            wait_r  <= '0;
            write_r <= 1'b0;
            done    <= 1'b0;
            rdata   <= 8'h00;
            ceN     <= 1'b1;
            oeN     <= 1'b1;
            weN     <= 1'b1;
            addrOut <= '0;
            dqOut   <= 8'h00;
            dqOe    <= 1'b0;
        end else begin
            done <= 1'b0;
            case (phase_r)
                PH_IDLE: begin
                    if (start) begin
                        write_r <= isWrite;
                        addrOut <= addr;
                        dqOut   <= wdata;
                        ceN     <= 1'b0;
                        oeN     <= isWrite;
                        dqOe    <= isWrite;
                        phase_r <= PH_SETUP;
                    end
                end
                PH_SETUP: begin
                    if (write_r) begin
                        weN    <= 1'b0;
                        wait_r <= 4'(flash_host_pkg::WE_LOW_CYC - 1);
                    end else begin
                        wait_r <= 4'(flash_host_pkg::READ_WAIT_CYC - 1);
                    end
                    phase_r <= PH_STROBE;
                end
                PH_STROBE: begin
                    if (wait_r != '0) begin
                        wait_r <= wait_r - 4'h1;
                    end else begin
                        weN     <= 1'b1;
                        rdata   <= dqSync_r;
                        oeN     <= 1'b1;
                        phase_r <= PH_HOLD;
                    end
                end
                PH_HOLD: begin
                    ceN     <= 1'b1;
                    phase_r <= PH_RECOVER;
                end
                default: begin
                    dqOe    <= 1'b0;
                    done    <= 1'b1;
                    phase_r <= PH_IDLE;
                end
            endcase
        end
    end

endmodule

/* sim/flash_host_ctrl_asserts.sv */
// pin and handshake checks for the parallel flash host controller
// assumes binding onto flash_host_ctrl, one clk domain
module flash_host_ctrl_asserts (
    input wire logic                              clk,        // clock
    input wire logic                              reset_n,    // async low
    input wire logic                              cmdReady,   // idle
    input wire logic                              flashCeN,   // chip sel
    input wire logic                              flashOeN,   // out gate
    input wire logic                              flashWeN,   // wr strobe
    input wire logic [flash_host_pkg::ADDR_W-1:0] flashAddr,  // addr pins
    input wire logic [flash_host_pkg::DATA_W-1:0] flashDqOut, // dq drive
    input wire logic                              flashDqOe   // dq enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // strobe shape: the device latches on edges, so pins must sit still
    AST_WE_UNDER_CE: assert property (!flashWeN |-> !flashCeN)
        else $error("write strobe low without chip select");
    AST_WE_NOT_OE: assert property (!flashWeN |-> flashOeN && flashDqOe)
        else $error("write strobe low with gate low or bus released");
    AST_WE_PULSE: assert property ($fell(flashWeN) |-> !flashWeN[*3] ##1 flashWeN)
        else $error("write strobe pulse not three cycles");
    AST_ADDR_HELD: assert property (!flashWeN |-> $stable(flashAddr) && $stable(flashDqOut))
        else $error("address or data moved under write strobe");
    AST_DATA_AT_RISE: assert property ($rose(flashWeN) |-> !flashCeN && flashDqOe && $stable(flashDqOut))
        else $error("data not held at write strobe rise");
    AST_NO_CLASH: assert property (!flashOeN |-> !flashDqOe)
        else $error("host drives data while gate low");
    AST_READ_GATE: assert property ($fell(flashOeN) |-> (!flashOeN && !flashCeN)[*4])
        else $error("read gate shorter than access wait");
    AST_IDLE_DESEL: assert property (cmdReady |-> flashCeN && flashWeN && flashOeN)
        else $error("pins active while idle");
endmodule

bind flash_host_ctrl flash_host_ctrl_asserts chk (.clk(clk), .reset_n(reset_n),
    .cmdReady(cmdReady), .flashCeN(flashCeN), .flashOeN(flashOeN),
    .flashWeN(flashWeN), .flashAddr(flashAddr), .flashDqOut(flashDqOut),
    .flashDqOe(flashDqOe));

/* sim/flash_device_model.sv */
// behavioural byte-wide flash answering the host controller's pins
// assumes only the low 11 address bits matter, to keep memory small
module flash_device_model #(
    parameter int PROG_NS  = 4000,  // program busy time, under 20 us
    parameter int ERASE_NS = 30000  // erase busy time, plain default
) (
    input  wire logic [18:0] addr, // address pins
    input  wire logic [7:0]  dq,   // data from host
    input  wire logic        ceN,  // chip select
    input  wire logic        oeN,  // output gate
    input  wire logic        weN,  // write strobe
    output logic      [7:0]  q,    // data to pins
    output logic             oe    // driving pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [0:2047];
    logic [18:0] la, pa;
    logic [7:0]  pd;
    logic        busy = 0, ers = 0, tog = 0, prog = 0;
    int          step = 0;
    wire         wr = ceN | weN;
    wire         rd = ceN | oeN;
    initial foreach (mem[i]) mem[i] = 8'hff;
    // address at the later fall, data at the earlier rise of the strobes
    always @(negedge wr) la = addr;
    always @(negedge rd) if (busy) tog = ~tog;
    assign oe = !rd;
    assign q = !busy ? mem[addr[10:0]] : {ers ? 1'b0 : ~pd[7], tog, 6'h00};
    function automatic bit ok(int s, logic [18:0] a, logic [7:0] d);
        if (s == 0 || s == 3) return a == flash_host_pkg::UNLOCK1_ADDR && d == flash_host_pkg::UNLOCK1_DATA;
        if (s == 1 || s == 4) return a == flash_host_pkg::UNLOCK2_ADDR && d == flash_host_pkg::UNLOCK2_DATA;
        return a == flash_host_pkg::UNLOCK1_ADDR && (d == flash_host_pkg::PROG_SETUP || d == flash_host_pkg::ERASE_SETUP);
    endfunction
    task automatic run(input int t, input int kind);
        busy = 1;
        ers = kind != 0;
        pa = la;
        fork begin
            #t;
            if (kind == 0) mem[pa[10:0]] = pd;
            foreach (mem[i]) if (kind == 2 || (kind == 1 && i[10:7] == pa[10:7])) mem[i] = 8'hff;
            busy = 0;
        end join_none
    endtask
    // a busy device drops every write; a wrong cycle drops the sequence
    always @(posedge wr) begin
        if (busy) step = step;
        else if (step == 3 && prog) begin
            pd = dq;
            step = 0;
            run(PROG_NS, 0);
        end else if (step == 5) begin
            step = 0;
            if (dq == flash_host_pkg::SECTOR_ERASE) run(ERASE_NS, 1);
            else if (dq == flash_host_pkg::CHIP_ERASE && la == flash_host_pkg::CHIP_ERASE_AD) run(ERASE_NS, 2);
        end else if (ok(step, la, dq)) begin
            if (step == 2) prog = dq == flash_host_pkg::PROG_SETUP;
            step++;
        end else step = 0;
    end
endmodule

/* sim/parallel_flash_command_engine_test.sv */
// self-checking bench: host controller against the flash model
// assumes the checker is bound in through its own file
module parallel_flash_command_engine_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PROG_NS = 4000;
    logic clk = 0, reset_n = 0, cmdValid = 0;
    logic [1:0] cmdOp = 2'h0;
    logic [18:0] cmdAddr = 19'h00000, fAddr;
    logic [7:0] cmdData = 8'h00, rspData, dqOut, devQ, dqIn, junk = 8'h00;
    logic cmdReady, rspValid, rspError, ceN, oeN, weN, dqOe, devOe;
    logic [7:0] r;
    logic e;
    int err_count = 0, check_count = 0;
    initial forever #20 clk = ~clk;
    // a released bus wanders each cycle so a stale byte cannot pass
    always @(posedge clk) junk <= junk + 8'h3b;
    assign dqIn = devOe ? devQ : dqOe ? dqOut : junk;
    flash_host_ctrl DUT (.clk(clk), .reset_n(reset_n), .cmdValid(cmdValid),
        .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData(cmdData),
        .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData),
        .rspError(rspError), .flashCeN(ceN), .flashOeN(oeN), .flashWeN(weN),
        .flashAddr(fAddr), .flashDqOut(dqOut), .flashDqOe(dqOe),
        .flashDqIn(dqIn));
    flash_device_model #(.PROG_NS(PROG_NS)) dev (.addr(fAddr), .dq(dqOut),
        .ceN(ceN), .oeN(oeN), .weN(weN), .q(devQ), .oe(devOe));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("checks=%0d mismatches=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // one request, held until taken, then a bounded wait for the answer
    task automatic op(input logic [1:0] o, input logic [18:0] a, input logic [7:0] d);
        int n = 0;
        cmdValid <= 1;
        cmdOp <= o;
        cmdAddr <= a;
        cmdData <= d;
        do @(posedge clk); while (cmdReady !== 1);
        cmdValid <= 0;
        while (rspValid !== 1 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        if (n == 5000) err_count++;
        r = rspData;
        e = rspError;
    endtask
    task automatic t_prog;
        time t0;
        op(flash_host_pkg::OP_READ, 19'h00100, 8'h00);
        check(r, 8'hff);
        t0 = $time;
        op(flash_host_pkg::OP_PROG, 19'h00100, 8'h3c);
        check(e, 1'b0);
        check(r, 8'h3c);
        check($time - t0 > PROG_NS, 1'b1);
        op(flash_host_pkg::OP_PROG, 19'h00200, 8'hc3);
        check(e, 1'b0);
        check(r, 8'hc3);
        op(flash_host_pkg::OP_READ, 19'h00100, 8'h00);
        check(r, 8'h3c);
        $display("program test done");
    endtask
    task automatic t_erase;
        op(flash_host_pkg::OP_SECTOR, 19'h00105, 8'h00);
        check(e, 1'b0);
        check(r, 8'hff);
        op(flash_host_pkg::OP_READ, 19'h00100, 8'h00);
        check(r, 8'hff);
        op(flash_host_pkg::OP_READ, 19'h00200, 8'h00);
        check(r, 8'hc3);
        op(flash_host_pkg::OP_CHIP, 19'h00000, 8'h00);
        check(e, 1'b0);
        check(r, 8'hff);
        op(flash_host_pkg::OP_READ, 19'h00200, 8'h00);
        check(r, 8'hff);
        $display("erase test done");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1;
        @(posedge clk);
        check({cmdReady, ceN, oeN, weN, dqOe, rspValid}, 6'h3c);
        $display("idle test done");
        t_prog;
        t_erase;
        conclude;
    end
    // the run should end near 85 us; stop well after that
    initial begin
        #2000000;
        err_count++;
        conclude;
    end
endmodule
